// ==== hdl/sdw_pin_sync.sv ====
// three-stage sampler for every link pin plus clock and strobe edge finder
// assumes the link pins toggle far slower than the system clock
`timescale 1ns/1ps
module sdw_pin_sync (
    input  wire logic        clock,   // system clock
    input  wire logic        reset,   // synchronous, active high
    input  wire logic        ck,      // command clock from controller
    input  wire logic        dqs,     // write strobe
    input  wire logic        cs_n,    // chip select
    input  wire logic        ras_n,   // row strobe
    input  wire logic        cas_n,   // column strobe
    input  wire logic        we_n,    // write enable
    input  wire logic [2:0]  ba,      // bank address
    input  wire logic [12:0] addr,    // address
    input  wire logic [15:0] dq,      // write data
    input  wire logic [1:0]  dm,      // byte mask
    sdw_pins_if.sync         pins     // sampled view
);

    typedef struct packed {
        logic [sdw_pkg::PIN_W-1:0] s1;
        logic [sdw_pkg::PIN_W-1:0] s2;
        logic [sdw_pkg::PIN_W-1:0] s3;
        logic [sdw_pkg::PIN_W-1:0] stable;
        logic                      ck_prev;
        logic                      dqs_prev;
    } sdw_sync_s;

    sdw_sync_s r;
    sdw_sync_s next_r;
    logic [sdw_pkg::PIN_W-1:0] agree;

    // ---------------------------------------------------------------
    // sampling
    // ---------------------------------------------------------------
    // a bit only moves once stages two and three agree, so a glitch is dropped
    always_comb
    begin
        next_r        = r;
        next_r.s1     = {ck, dqs, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dm};
        next_r.s2     = r.s1;
        next_r.s3     = r.s2;
        agree         = ~(r.s2 ^ r.s3);
        next_r.stable = (r.s3 & agree) | (r.stable & ~agree);
        next_r.ck_prev  = r.stable[39];
        next_r.dqs_prev = r.stable[38];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            r <= '0;
        else
            r <= next_r;
    end

    // edges are one-cycle pulses on the settled copies
    assign pins.ck_rise  = r.stable[39] & ~r.ck_prev;
    assign pins.dqs_edge = r.stable[38] ^ r.dqs_prev;
    assign pins.cs_n     = r.stable[37];
    assign pins.cmd      = r.stable[36:34];
    assign pins.ba       = r.stable[33:31];
    assign pins.addr     = r.stable[30:18];
    assign pins.dq       = r.stable[17:2];
    assign pins.dm       = r.stable[1:0];

endmodule

// ==== hdl/sdw_pins_if.sv ====
// synchronised link pins passed from the pin sampler to the core
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface sdw_pins_if;
    logic        ck_rise;
    logic        dqs_edge;
    logic        cs_n;
    logic [2:0]  cmd;
    logic [2:0]  ba;
    logic [12:0] addr;
    logic [15:0] dq;
    logic [1:0]  dm;
    modport sync (output ck_rise, dqs_edge, cs_n, cmd, ba, addr, dq, dm);
    modport core (input ck_rise, dqs_edge, cs_n, cmd, ba, addr, dq, dm);
endinterface

// ==== hdl/sdw_pkg.sv ====
// constants and types shared by the write and refresh logic
// assumes one 100 MHz system clock and an AHB-Lite master for the registers
package sdw_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int DQ_W   = 16;
    localparam int LANES  = 2;
    localparam int COL_W  = 4;
    localparam int ADDR_W = 13;
    localparam int PIN_W  = 40;

    // ---------------------------------------------------------------
    // register byte offsets, fields and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_REFRESH = 8'h08;
    localparam logic [7:0] OFS_WRITES  = 8'h0c;
    localparam logic [7:0] OFS_PEEK    = 8'h10;
    localparam int MODE_BURST_LSB = 0;
    localparam int MODE_AL_LSB    = 4;
    localparam int MODE_CWL_LSB   = 8;
    localparam logic [1:0] MODE_BURST_RST = 2'h1;
    localparam logic [3:0] MODE_AL_RST    = 4'h0;
    localparam logic [3:0] MODE_CWL_RST   = 4'h5;

    // ---------------------------------------------------------------
    // burst selection and timing counts
    // ---------------------------------------------------------------
    localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BURST_ON_THE_FLY  = 2'h1;
    localparam logic [1:0] BURST_FIXED_CHOP  = 2'h2;
    localparam int BURST_SELECT_BIT = 12;
    localparam logic [3:0] BEATS_CHOP  = 4'h4;
    localparam logic [3:0] BEATS_EIGHT = 4'h8;
    localparam logic [3:0] STALL_MAX   = 4'h7;

    // ---------------------------------------------------------------
    // commands as {row strobe, column strobe, write enable}
    // ---------------------------------------------------------------
    typedef logic [2:0] sdw_cmd_t;
    localparam sdw_cmd_t CMD_REFRESH   = 3'h1;
    localparam sdw_cmd_t CMD_PRECHARGE = 3'h2;
    localparam sdw_cmd_t CMD_ACTIVATE  = 3'h3;
    localparam sdw_cmd_t CMD_WRITE     = 3'h4;
    localparam sdw_cmd_t CMD_READ      = 3'h5;

    typedef enum logic [1:0] {
        W_IDLE    = 2'b00,
        W_LATENCY = 2'b01,
        W_BEATS   = 2'b11
    } sdw_wstate_e;

endpackage

// ==== hdl/sdw_write_refresh.sv ====
// write burst capture and refresh command handling of a dram device
// assumes an AHB-Lite master on the system clock and a controller on the pins
//
// Operation
// - on-the-fly mode, address bit 12 picks chopped four or eight beats
// - eight beats when mode is fixed eight, or on-the-fly with bit 12 high
// - mode code 10 forces chopped four-beat bursts regardless of bit 12
// - data-to-strobe violations corrupt only the addressed burst, never hang
// - strobe shape or clock violations corrupt only the target, never hang
// - write latency equals additive latency plus cas write latency
// - one mask bit per byte lane suppresses that byte, sampled like data
// - mask is ignored outside write bursts, including reads
// - chip select, row and column strobe low, write enable high is refresh
// - internal counter supplies refresh rows; all banks end precharged
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module sdw_write_refresh (
    input  wire logic        clock,     // system clock, 100 MHz
    input  wire logic        reset,     // synchronous, active high
    input  wire logic        hsel,      // slave select
    input  wire logic [31:0] haddr,     // byte address
    input  wire logic [1:0]  htrans,    // transfer type
    input  wire logic        hwrite,    // write when high
    input  wire logic [2:0]  hsize,     // word only
    input  wire logic [31:0] hwdata,    // write data
    input  wire logic        hready,    // bus ready
    output logic             hreadyout, // always ready
    output logic [31:0]      hrdata,    // read data
    output logic             hresp,     // always okay
    input  wire logic        ck,        // command clock
    input  wire logic        cs_n,      // chip select
    input  wire logic        ras_n,     // row strobe
    input  wire logic        cas_n,     // column strobe
    input  wire logic        we_n,      // write enable
    input  wire logic [2:0]  ba,        // bank address
    input  wire logic [12:0] addr,      // address
    input  wire logic        dqs,       // write strobe
    input  wire logic [15:0] dq,        // write data
    input  wire logic [1:0]  dm         // write byte mask
);

    typedef struct packed {
        logic [1:0]          burst;
        logic [3:0]          al;
        logic [3:0]          cas_write_latency;
        logic [3:0]          peek;
        logic                a_mode;
        logic                a_peek;
        logic [31:0]         hrdata;
        sdw_pkg::sdw_wstate_e wst;
        logic [4:0]          lat;
        logic [3:0]          beat;
        logic [3:0]          stall;
        logic [3:0]          col;
        logic                eight;
        logic                pend_v;
        logic [3:0]          pend_col;
        logic                pend_eight;
        logic [4:0]          pend_lat;
        logic [7:0]          bank_open;
        logic [15:0]         refresh_count;
        logic [12:0]         ref_row;
        logic [15:0]         write_count;
        logic [7:0]          drops;
    } sdw_state_s;

    sdw_state_s   r;
    sdw_state_s   next_r;
    sdw_pins_if   p ();
    logic [1:0]   lane_we;
    logic [3:0]   mem_idx;
    logic [15:0]  peek_data;
    logic         accept;
    logic         finish;
    logic         wr_eight;
    logic [4:0]   wl_sum;
    logic [4:0]   wr_lat;
    logic [3:0]   len;
    logic         cmd_go;
    logic         wcmd;
    logic         refcmd;
    logic         wstart;

    // ---------------------------------------------------------------
    // pin sampling
    // ---------------------------------------------------------------
    sdw_pin_sync u_sync (
        .clock (clock),
        .reset (reset),
        .ck    (ck),
        .dqs   (dqs),
        .cs_n  (cs_n),
        .ras_n (ras_n),
        .cas_n (cas_n),
        .we_n  (we_n),
        .ba    (ba),
        .addr  (addr),
        .dq    (dq),
        .dm    (dm),
        .pins  (p.sync)
    );

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    assign accept = hsel && htrans[1] && hready;
    assign cmd_go = p.ck_rise && !p.cs_n;
    assign wcmd   = cmd_go && (p.cmd == sdw_pkg::CMD_WRITE);
    assign refcmd = cmd_go && (p.cmd == sdw_pkg::CMD_REFRESH);
    assign wstart = wcmd && (r.wst == sdw_pkg::W_IDLE) && !r.pend_v;
    assign len    = r.eight ? sdw_pkg::BEATS_EIGHT : sdw_pkg::BEATS_CHOP;
    assign wl_sum = {1'b0, r.al} + {1'b0, r.cas_write_latency};
    // arm one clock early: the preamble holds the strobe low until beat zero
    assign wr_lat = (wl_sum == 5'h0) ? 5'h0 : wl_sum - 5'h1;

    // burst length picked from the mode and the sampled select bit
    always_comb
    begin
        unique case (r.burst)
            sdw_pkg::BURST_FIXED_EIGHT: wr_eight = 1'b1;
            sdw_pkg::BURST_ON_THE_FLY:  wr_eight = p.addr[sdw_pkg::BURST_SELECT_BIT];
            sdw_pkg::BURST_FIXED_CHOP:  wr_eight = 1'b0;
            default:                    wr_eight = 1'b1;
        endcase
    end

    // ---------------------------------------------------------------
    // write data storage, one array per byte lane
    // ---------------------------------------------------------------
    // burst order wraps inside its own block, so a broken burst stays local
    always_comb
    begin
        if (r.eight)
            mem_idx = {r.col[3], r.col[2:0] + r.beat[2:0]};
        else
            mem_idx = {r.col[3:2], r.col[1:0] + r.beat[1:0]};
    end

    for (genvar gi = 0; gi < sdw_pkg::LANES; gi++)
    begin : g_lane
        logic [7:0] mem [0:(1 << sdw_pkg::COL_W) - 1];

        // a masked byte keeps its old contents
        always_ff @(posedge clock)
        begin
            if (lane_we[gi])
                mem[mem_idx] <= p.dq[gi*8 +: 8];
        end

        assign peek_data[gi*8 +: 8] = mem[r.peek];
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_r  = r;
        lane_we = '0;
        finish  = 1'b0;

        // register write data phase
        if (r.a_mode)
        begin
            next_r.burst = hwdata[sdw_pkg::MODE_BURST_LSB +: 2];
            next_r.al    = hwdata[sdw_pkg::MODE_AL_LSB +: 4];
            next_r.cas_write_latency   = hwdata[sdw_pkg::MODE_CWL_LSB +: 4];
        end
        if (r.a_peek)
            next_r.peek = hwdata[3:0];

        // a queued command counts down its latency alongside the active one
        if (p.ck_rise && r.pend_v && (r.pend_lat != 5'h0))
            next_r.pend_lat = r.pend_lat - 5'h1;

        unique case (r.wst)
            sdw_pkg::W_IDLE:
            begin
            end
            sdw_pkg::W_LATENCY:
            begin
                if (r.lat == 5'h0)
                begin
                    next_r.wst   = sdw_pkg::W_BEATS;
                    next_r.beat  = 4'h0;
                    next_r.stall = 4'h0;
                end
                else if (p.ck_rise)
                    next_r.lat = r.lat - 5'h1;
            end
            sdw_pkg::W_BEATS:
            begin
                if (p.dqs_edge)
                begin
                    // every strobe edge carries one beat, mask only here
                    lane_we     = ~p.dm;
                    next_r.beat = r.beat + 4'h1;
                    if (r.beat == len - 4'h1)
                    begin
                        finish             = 1'b1;
                        next_r.write_count = r.write_count + 16'h1;
                    end
                end
                else if (p.ck_rise)
                begin
                    // missing strobe edges end the burst instead of hanging
                    if (r.stall == sdw_pkg::STALL_MAX)
                    begin
                        finish       = 1'b1;
                        next_r.drops = r.drops + 8'h1;
                    end
                    else
                        next_r.stall = r.stall + 4'h1;
                end
            end
            default:
                next_r.wst = sdw_pkg::W_IDLE;
        endcase

        // on completion, start the queued burst if one waits
        if (finish)
        begin
            next_r.wst = sdw_pkg::W_IDLE;
            if (r.pend_v)
            begin
                next_r.wst    = sdw_pkg::W_LATENCY;
                next_r.col    = r.pend_col;
                next_r.eight  = r.pend_eight;
                next_r.lat    = next_r.pend_lat;
                next_r.pend_v = 1'b0;
            end
        end

        // command decode on each rising command clock
        if (cmd_go)
        begin
            unique case (p.cmd)
                sdw_pkg::CMD_WRITE:
                begin
                    // bit 12 is burst control only, never a column bit
                    if (next_r.wst == sdw_pkg::W_IDLE)
                    begin
                        next_r.wst   = sdw_pkg::W_LATENCY;
                        next_r.col   = p.addr[3:0];
                        next_r.eight = wr_eight;
                        next_r.lat   = wr_lat;
                    end
                    else
                    begin
                        next_r.pend_v     = 1'b1;
                        next_r.pend_col   = p.addr[3:0];
                        next_r.pend_eight = wr_eight;
                        next_r.pend_lat   = wr_lat;
                    end
                end
                sdw_pkg::CMD_ACTIVATE:
                    next_r.bank_open[p.ba] = 1'b1;
                sdw_pkg::CMD_PRECHARGE:
                begin
                    if (p.addr[10])
                        next_r.bank_open = 8'h00;
                    else
                        next_r.bank_open[p.ba] = 1'b0;
                end
                sdw_pkg::CMD_REFRESH:
                begin
                    // address pins are ignored, the row comes from the counter
                    next_r.refresh_count = r.refresh_count + 16'h1;
                    next_r.ref_row       = r.ref_row + 13'h1;
                    next_r.bank_open     = 8'h00;
                end
                default:
                begin
                    // reads and others: mask pins are not looked at
                end
            endcase
        end

        // register address phase; mode and peek index reads see this cycle's write already, peek data still comes from the old index
        next_r.a_mode = 1'b0;
        next_r.a_peek = 1'b0;
        if (accept)
        begin
            next_r.a_mode = hwrite && (haddr[7:0] == sdw_pkg::OFS_MODE);
            next_r.a_peek = hwrite && (haddr[7:0] == sdw_pkg::OFS_PEEK);
            if (!hwrite)
            begin
                unique case (haddr[7:0])
                    sdw_pkg::OFS_MODE:
                        next_r.hrdata = (32'(next_r.burst) << sdw_pkg::MODE_BURST_LSB)
                                      | (32'(next_r.al) << sdw_pkg::MODE_AL_LSB)
                                      | (32'(next_r.cas_write_latency) << sdw_pkg::MODE_CWL_LSB);
                    sdw_pkg::OFS_STATUS:
                        next_r.hrdata = {8'h00, r.drops, r.bank_open, 4'h0,
                                         r.eight, r.pend_v, r.wst};
                    sdw_pkg::OFS_REFRESH:
                        next_r.hrdata = {3'h0, r.ref_row, r.refresh_count};
                    sdw_pkg::OFS_WRITES:
                        next_r.hrdata = {16'h0000, r.write_count};
                    sdw_pkg::OFS_PEEK:
                        next_r.hrdata = {12'h000, next_r.peek, peek_data};
                    default:
                        next_r.hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            r       <= '0;
            r.burst <= sdw_pkg::MODE_BURST_RST;
            r.al    <= sdw_pkg::MODE_AL_RST;
            r.cas_write_latency   <= sdw_pkg::MODE_CWL_RST;
            r.wst   <= sdw_pkg::W_IDLE;
        end
        else
            r <= next_r;
    end

    // zero wait states keep the slave simple; every answer is okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = r.hrdata;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    property p_otf_chop;
        wstart && (r.burst == sdw_pkg::BURST_ON_THE_FLY) && !p.addr[12] |=> !r.eight;
    endproperty
    a_otf_chop: assert property (p_otf_chop)
        else $error("on-the-fly chop not selected");

    property p_eight;
        wstart && ((r.burst == sdw_pkg::BURST_FIXED_EIGHT)
            || ((r.burst == sdw_pkg::BURST_ON_THE_FLY) && p.addr[12])) |=> r.eight;
    endproperty
    a_eight: assert property (p_eight)
        else $error("eight-beat burst not selected");

    property p_fixed_chop;
        wstart && (r.burst == sdw_pkg::BURST_FIXED_CHOP) |=> !r.eight;
    endproperty
    a_fixed_chop: assert property (p_fixed_chop)
        else $error("fixed chop mode gave eight beats");

    property p_stall_drop;
        (r.wst == sdw_pkg::W_BEATS) && (r.stall == sdw_pkg::STALL_MAX)
            && p.ck_rise && !p.dqs_edge |=> (r.drops == $past(r.drops) + 8'h1);
    endproperty
    a_stall_drop: assert property (p_stall_drop)
        else $error("stalled burst not abandoned");

    property p_local;
        (lane_we != 2'b00) |-> (mem_idx[3] == r.col[3]);
    endproperty
    a_local: assert property (p_local)
        else $error("beat written outside its burst block");

    property p_latency;
        wstart |=> (r.lat == $past(wr_lat)) && (r.wst == sdw_pkg::W_LATENCY);
    endproperty
    a_latency: assert property (p_latency)
        else $error("write latency not loaded");

    property p_mask;
        (lane_we & p.dm) == 2'b00;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked byte was written");

    property p_no_write_outside;
        (lane_we != 2'b00) |-> (r.wst == sdw_pkg::W_BEATS) && p.dqs_edge;
    endproperty
    a_no_write_outside: assert property (p_no_write_outside)
        else $error("write outside a burst beat");

    property p_refresh;
        refcmd |=> (r.refresh_count == $past(r.refresh_count) + 16'h1);
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("refresh not counted");

    property p_refresh_row;
        refcmd |=> (r.bank_open == 8'h00) && (r.ref_row == $past(r.ref_row) + 13'h1);
    endproperty
    a_refresh_row: assert property (p_refresh_row)
        else $error("refresh row or banks wrong");

    c_eight_done: cover property (finish && r.eight && (r.beat == 4'h7));
    c_chop_done: cover property (finish && !r.eight && (r.beat == 4'h3));
    c_refresh: cover property (refcmd);
    c_dropped: cover property ((r.stall == sdw_pkg::STALL_MAX) && p.ck_rise && !p.dqs_edge);

endmodule

// ==== verification/sdw_ctrl_model.sv ====
// controller model driving commands and write bursts on the link pins
// assumes the bench calls its tasks; ck stands still between frames
`timescale 1ns/1ps
module sdw_ctrl_model (
    output logic        ck,   // command clock
    output logic        cs_n, // chip select
    output logic [2:0]  cmd,  // row, column strobe, write enable
    output logic [12:0] addr, // address
    output logic        dqs,  // write strobe
    output logic [15:0] dq,   // write data
    output logic [1:0]  dm    // byte mask
);
    initial {ck, dqs, cs_n, cmd, addr, dq, dm} = {6'hf, 31'h0};
    // one command per frame; banks never opened, idle after refresh
    // no read or precharge ever follows a burst
    // refreshes come in short runs, far inside the postpone, pull-in and window limits,
    // and self-refresh is never entered
    task automatic issue(input logic [2:0] c, input logic [12:0] a);
        // start off the system clock's edges; back-to-back frames raise chip select and cmd for only 2 ns, between clock edges
        #2 {cs_n, cmd, addr} = {1'b0, c, a};
        #80 ck = 1'b1;
        #80 ck = 1'b0;
        {cs_n, cmd} = 4'hf;
    endtask
    // data settles 40 ns ahead; every strobe edge sits on a ck edge
    task automatic burst(input logic [12:0] a, input int n, input logic [127:0] d,
                         input logic [15:0] m, input int wl);
        issue(3'h4, a);
        repeat (wl - 1)
        begin
            #80 ck = 1'b1;
            #80 ck = 1'b0;
        end
        for (int k = 0; k < n; k++)
        begin
            #40 {dq, dm} = {d[16 * k +: 16], m[2 * k +: 2]};
            #40 {ck, dqs} = {~ck, ~dqs};
        end
        #40 dq = ~dq; // released data never shows a stale value
    endtask
endmodule

// ==== verification/test_sdw_write_refresh.sv ====
// bench: bus reads matched against a queue of expected words
// assumes one bus slave and the controller model on the link
`timescale 1ns/1ps
module test_sdw_write_refresh;
    logic        clock, reset, hsel, hwrite, hreadyout, hresp, ck, cs_n, dqs, rd_ph;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, dm;
    logic [2:0]  cmd;
    logic [12:0] addr;
    logic [15:0] dq;
    logic [15:0] mem [16];
    logic [31:0] expq [$];
    int          num_errors = 0;
    int          checked = 0;
    int          seed = 32'h01a8a485;
    sdw_write_refresh sdw_write_refresh_i (.clock, .reset, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ck, .cs_n,
        .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba(3'h0), .addr, .dqs, .dq, .dm);
    sdw_ctrl_model sdw_ctrl_model_i (.ck, .cs_n, .cmd, .addr, .dqs, .dq, .dm);
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // oldest note is taken when a read's data phase ends
    always @(posedge clock)
        if (rd_ph)
        begin
            cmp("hrdata", expq.pop_front(), hrdata);
            cmp("hresp", 32'h0000_0000, {31'h0, hresp});
        end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata, rd_ph} <= {1'b0, 2'h0, v, ~w};
        if (!w)
            expq.push_back(v);
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    // expected array follows the wrap inside the 4 or 8 block
    // cut beats are left off the end, so the strobe stops short of the burst
    task automatic wr(input logic [12:0] a, input int n, input logic [15:0] m, input int wl,
                      input int cut = 0);
        logic [127:0] d;
        logic [3:0]   i;
        d = {$random(seed), $random(seed), $random(seed), $random(seed)};
        for (int k = 0; k < n - cut; k++)
        begin
            i = (n == 8) ? {a[3], 3'(a[2:0] + k)} : {a[3:2], 2'(a[1:0] + k)};
            for (int l = 0; l < 2; l++)
                if (!m[2 * k + l])
                    mem[i][8 * l +: 8] = d[16 * k + 8 * l +: 8];
        end
        sdw_ctrl_model_i.burst(a, n - cut, d, m, wl);
        repeat (8) @(posedge clock);
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        {hsel, htrans, hwrite, haddr, hwdata, rd_ph} = '0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (5) @(posedge clock);
        ahb(1'b0, 8'h00, 32'h0000_0501);
        wr(13'h1000, 8, 16'h0000, 5);
        wr(13'h0002, 4, 16'h0008, 5);
        ahb(1'b1, 8'h00, 32'h0000_0512);
        wr(13'h1008, 4, 16'h0000, 6);
        ahb(1'b1, 8'h00, 32'h0000_0500);
        wr(13'h0004, 8, 16'h4100, 5);
        // strobe stops after four of eight beats; the refresh clocks then abandon it
        wr(13'h000c, 8, 16'h0000, 5, 4);
        repeat (8)
        begin
            sdw_ctrl_model_i.issue(3'h1, 13'($random(seed)));
        end
        repeat (8) @(posedge clock);
        ahb(1'b0, 8'h0c, 32'h0000_0004);
        ahb(1'b0, 8'h08, 32'h0008_0008);
        ahb(1'b0, 8'h04, 32'h0001_0008);
        ahb(1'b0, 8'h20, 32'h0000_0000);
        for (int j = 0; j < 16; j++)
        begin
            ahb(1'b1, 8'h10, 32'(j));
            ahb(1'b0, 8'h10, {12'h0, 4'(j), mem[j]});
        end
        report_and_stop();
    end
    // a hung bus or burst ends the run here
    initial
    begin
        #600000;
        num_errors++;
        report_and_stop();
    end
endmodule
